// ---- dv/triple_comparator_vref_control_tb_top.sv ----
module triple_comparator_vref_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, srst, hsel, hwrite, idle_mode; // Clock, reset, bus and idle stimulus
  logic [31:0] haddr, hwdata, hrdata; // Bus address and data
  logic [1:0] htrans; // Bus transfer type
  logic [2:0] hsize, raw, cmp_en, pin_en, use_ref, result, irq, trig; // Bus size, per-comparator pins
  logic hreadyout, hresp, v_pow, v_pin, v_fine, v_ext; // Slave answer, reference controls
  logic [5:0] inv_ch; // Inverting mux codes
  logic [3:0] v_lvl; // Reference level code
  logic [7:0] v_frac; // Reference level in 1/96 steps
  int miscompares, n_checks, seed; // Verdict counters, random seed
  int trig_cnt[3], irq_cnt[3]; // Pulse tallies per comparator

  // Design under test, single slave so its ready is the bus ready
  tcv_top tcv_top_inst (.SYS_CLK(sys_clk), .SRST(srst), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .IDLE_MODE(idle_mode),
    .RAW_CMP_OUT(raw), .CMP_ENABLE(cmp_en), .CMP_PIN_OUT_EN(pin_en), .NONINV_USE_REF(use_ref),
    .INV_CHANNEL(inv_ch), .CMP_RESULT(result), .CMP_IRQ(irq), .CMP_TRIGGER(trig),
    .VREF_POWER(v_pow), .VREF_PIN_EN(v_pin), .VREF_FINE_RANGE(v_fine),
    .VREF_EXT_SOURCE(v_ext), .VREF_LEVEL(v_lvl), .VREF_FRACTION(v_frac));

  // Free-running 40 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Tally one-cycle pulses; sampled before the edge's own updates land
  always @(posedge sys_clk) begin
    for (int k = 0; k < 3; k++) begin
      if (trig[k] === 1'b1) trig_cnt[k]++;
      if (irq[k] === 1'b1) irq_cnt[k]++;
    end
  end

  // Verdict, the only exit of the run
  task automatic stop_test;
    if (miscompares == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Single comparison, four-state exact
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask

  // Next edge with ready high, bounded so a stuck slave ends the run
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 100) begin
        miscompares++;
        stop_test();
      end
      @(posedge sys_clk);
    end
  endtask

  // One whole-word single transfer: address phase, then data phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= tcv_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    ahb(1'b1, a, wd, d);
  endtask

  // Read and compare under a mask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] d;
    ahb(1'b0, a, 32'h00000000, d);
    check(d & m, exp);
  endtask

  // Main sequence
  initial begin
    logic [31:0] wd, c;
    logic r0, p, f, idl;
    int k, t0, q0;
    seed = 32'h1776;
    srst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = tcv_pkg::HSIZE_WORD;
    hwdata = 32'h00000000;
    idle_mode = 1'b0;
    raw = 3'h0;
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    // Every register clears on reset; unmapped place stays zero
    for (int a = 0; a < 6; a++) rd_chk(8'(a * 4), 32'hFFFFFFFF, 32'h00000000);
    wr(8'h14, 32'hFFFFFFFF);
    rd_chk(8'h14, 32'hFFFFFFFF, 32'h00000000);
    check(hresp, tcv_pkg::HRESP_OKAY);
    // Mux routing, comparators kept off so no events intrude
    for (int i = 0; i < 12; i++) begin
      k = i % 3;
      wd = ($random(seed) & 32'hFFFF7DFC) | (i / 3);
      wr(8'(k * 4), wd);
      rd_chk(8'(k * 4), 32'hFFFFFEFF, wd & 32'h000060D3);
      check(use_ref[k], wd[4]);
      check(inv_ch[2*k+:2], wd[1:0]);
      check(pin_en[k], wd[14]);
      wr(8'(k * 4), 32'h00000000);
    end
    // Reference: both ranges, both sources, all level codes
    for (int i = 0; i < 64; i++) begin
      wd = ($random(seed) & 32'hFFFFFFC0) | i;
      wr(tcv_pkg::VREF_CTRL_OFF, wd);
      rd_chk(tcv_pkg::VREF_CTRL_OFF, 32'hFFFFFFFF, wd & 32'h000000FF);
      check(v_pow, wd[7]);
      check(v_pin, wd[6]);
      check(v_fine, wd[5]);
      check(v_ext, wd[4]);
      check(v_lvl, wd[3:0]);
      check(v_frac, wd[5] ? 8'(4 * (i % 16)) : 8'(24 + 3 * (i % 16)));
    end
    // Suppress interrupts in idle for the event sweep
    wr(tcv_pkg::STATUS_OFF, 32'h00008000);
    rd_chk(tcv_pkg::STATUS_OFF, 32'hFFFFF8F8, 32'h00008000);
    // Events: every edge code, both polarities, idle on and off
    for (int i = 0; i < 24; i++) begin
      k = i % 3;
      p = i[2];
      r0 = 1'($random(seed));
      idl = 1'($random(seed));
      raw[k] <= r0;
      idle_mode <= idl;
      c = 32'h00008000 | (p << 13) | ((i / 6) % 4 << 6);
      f = (c[7:6] == 2'h3) || (c[7:6] == 2'h1 && !r0) || (c[7:6] == 2'h2 && r0);
      repeat (8) @(posedge sys_clk);
      wr(8'(k * 4), c);
      repeat (8) @(posedge sys_clk);
      wr(8'(k * 4), c);
      repeat (8) @(posedge sys_clk);
      t0 = trig_cnt[k];
      q0 = irq_cnt[k];
      raw[k] <= !r0;
      repeat (8) @(posedge sys_clk);
      // Later flips stay blocked while the flag is up
      if (f) begin
        raw[k] <= r0;
        repeat (8) @(posedge sys_clk);
        raw[k] <= !r0;
        repeat (8) @(posedge sys_clk);
      end
      check(cmp_en[k], 1'b1);
      check(trig_cnt[k] - t0, f);
      check(irq_cnt[k] - q0, f && !idl);
      check(result[k], !r0 ^ p);
      rd_chk(8'(k * 4), 32'hFFFFFFFF, c | (f << 9) | ((!r0 ^ p) << 8));
      rd_chk(tcv_pkg::STATUS_OFF, (32'h101 << k), (f << (8 + k)) | ((!r0 ^ p) << k));
      wr(8'(k * 4), c);
      repeat (4) @(posedge sys_clk);
      rd_chk(tcv_pkg::STATUS_OFF, (32'h101 << k), ((!r0 ^ p) << k));
      wr(8'(k * 4), 32'h00000000);
    end
    stop_test();
  end
endmodule // triple_comparator_vref_control_tb_top

// ---- verilog/tcv_pkg.sv ----
package tcv_pkg;
  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] CMP1_CTRL_OFF = 8'h00;
  localparam logic [7:0] CMP2_CTRL_OFF = 8'h04;
  localparam logic [7:0] CMP3_CTRL_OFF = 8'h08;
  localparam logic [7:0] STATUS_OFF = 8'h0C;
  localparam logic [7:0] VREF_CTRL_OFF = 8'h10;
  localparam logic [7:0] IDLE_CTRL_OFF = 8'h14;
  // Comparator control field positions
  localparam int CC_ENABLE_BIT = 15;
  localparam int CC_PINOUT_BIT = 14;
  localparam int CC_INVERT_BIT = 13;
  localparam int CC_EVENT_BIT = 9;
  localparam int CC_RESULT_BIT = 8;
  localparam int CC_EDGE_LSB = 6;
  localparam int CC_NONINV_BIT = 4;
  localparam int CC_CHAN_LSB = 0;
  // Status field positions
  localparam int ST_IDLE_BIT = 15;
  localparam int ST_EVT_LSB = 8;
  localparam int ST_OUT_LSB = 0;
  // Reference control field positions
  localparam int VR_POWER_BIT = 7;
  localparam int VR_PIN_BIT = 6;
  localparam int VR_RANGE_BIT = 5;
  localparam int VR_SOURCE_BIT = 4;
  localparam int VR_LEVEL_LSB = 0;
  // Reset values
  localparam logic [15:0] CC_RESET = 16'h0000;
  localparam logic [7:0] VR_RESET = 8'h00;
  // Inverting input channel codes
  localparam logic [1:0] CH_PIN_B = 2'h0;
  localparam logic [1:0] CH_PIN_C = 2'h1;
  localparam logic [1:0] CH_PIN_D = 2'h2;
  localparam logic [1:0] CH_HALF_BG = 2'h3;
  // Event edge select codes
  localparam logic [1:0] EV_OFF = 2'h0;
  localparam logic [1:0] EV_RISE = 2'h1;
  localparam logic [1:0] EV_FALL = 2'h2;
  localparam logic [1:0] EV_ANY = 2'h3;
  // AHB transfer type, size and response codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

  // Per-comparator software settings
  typedef struct packed {
    logic enable;
    logic pin_out;
    logic output_invert;
    logic [1:0] event_edge_select;
    logic noninv_source_select;
    logic [1:0] inverting_channel_select;
  } tcv_cmp_cfg_t;

  // Reference generator settings
  typedef struct packed {
    logic reference_power_enable;
    logic reference_pin_enable;
    logic reference_range_select;
    logic reference_source_select;
    logic [3:0] reference_level_code;
  } tcv_vref_cfg_t;
endpackage : tcv_pkg

// ---- verilog/tcv_top.sv ----
// Summary of operation
// - Reference bit picks programmable reference or pin A
// - Channel code picks B, C, D or half bandgap
// - Idle suppress bit masks interrupts while idle
// - Status bits 10..8 mirror event flags
// - Status bits 2..0 mirror comparator outputs
// - Unimplemented status and reference bits read zero
// - Reference enable bit powers reference circuit
// - Reference output enable connects reference pin
// - Range bit selects fine or offset coarse range
// - Source bit picks external reference or supply
// - Level code sets output level in range
// - Event flag sets, blocks retrigger until cleared
// - Edge field: off, rise, fall, or any change
// - Invert bit inverts reported comparator output
//
// Chosen here: the AHB-Lite register port and the address map.
module tcv_top #(
  parameter int NUM_CMP = 3 // Comparator count
) (
  input wire logic SYS_CLK, // System clock, 40 MHz
  input wire logic SRST, // Synchronous reset, active high
  input wire logic HSEL, // AHB slave select
  input wire logic [31:0] HADDR, // AHB address
  input wire logic [1:0] HTRANS, // AHB transfer type
  input wire logic HWRITE, // AHB write
  input wire logic [2:0] HSIZE, // AHB size
  input wire logic [31:0] HWDATA, // AHB write data
  input wire logic HREADY, // AHB bus ready
  output logic [31:0] HRDATA, // AHB read data
  output logic HREADYOUT, // AHB slave ready
  output logic HRESP, // AHB response
  input wire logic IDLE_MODE, // Device is in Idle mode
  input wire logic [NUM_CMP-1:0] RAW_CMP_OUT, // Async comparator results
  output logic [NUM_CMP-1:0] CMP_ENABLE, // Comparator power on
  output logic [NUM_CMP-1:0] CMP_PIN_OUT_EN, // Comparator output to pin
  output logic [NUM_CMP-1:0] NONINV_USE_REF, // Non-inverting from reference
  output logic [2*NUM_CMP-1:0] INV_CHANNEL, // Inverting input mux code
  output logic [NUM_CMP-1:0] CMP_RESULT, // Reported (polarised) outputs
  output logic [NUM_CMP-1:0] CMP_IRQ, // One-cycle event interrupt pulses
  output logic [NUM_CMP-1:0] CMP_TRIGGER, // One-cycle event trigger pulses
  output logic VREF_POWER, // Reference circuit powered
  output logic VREF_PIN_EN, // Reference drives its pin
  output logic VREF_FINE_RANGE, // Fine range, step of 1/24
  output logic VREF_EXT_SOURCE, // External reference pins as source
  output logic [3:0] VREF_LEVEL, // Level code
  output logic [7:0] VREF_FRACTION // Level as fraction of source, /96
);

  // Only three status mirror slots exist per field
  if (NUM_CMP < 1 || NUM_CMP > 3) begin : g_num_cmp_check
    $error("NUM_CMP must be 1 to 3");
  end

  // Settings and flags
  tcv_pkg::tcv_cmp_cfg_t cfg_q [NUM_CMP]; // Per-comparator settings
  tcv_pkg::tcv_vref_cfg_t vref_q; // Reference settings
  logic [NUM_CMP-1:0] evt_q; // Sticky event flags
  logic idle_sup_q; // Idle interrupt suppress
  logic [NUM_CMP-1:0] sync1_q; // Synchroniser first stage
  logic [NUM_CMP-1:0] sync2_q; // Synchroniser second stage
  logic [NUM_CMP-1:0] res_q; // Previous reported result
  logic [NUM_CMP-1:0] res_d; // Current reported result
  logic [NUM_CMP-1:0] fire_d; // Event condition this cycle
  logic [NUM_CMP-1:0] trig_q; // Registered trigger pulses
  logic [NUM_CMP-1:0] irq_q; // Registered interrupt pulses
  logic idle_s1_q; // Idle level sync stage 1
  logic idle_s2_q; // Idle level sync stage 2
  // Bus data phase capture
  logic wr_pend_q; // Write data phase pending
  logic [7:0] addr_q; // Captured byte offset
  logic [31:0] rdata_q; // Read data register
  logic addr_ok; // Address phase accepted
  logic [31:0] rd_word; // Read mux output

  // Map an offset onto a comparator index, NUM_CMP when none
  function automatic int cmp_index(input logic [7:0] off);
    int idx;
    idx = NUM_CMP;
    for (int i = 0; i < NUM_CMP; i++) begin
      if (off == tcv_pkg::CMP1_CTRL_OFF + 8'(4 * i)) begin
        idx = i;
      end
    end
    return idx;
  endfunction

  // Pack a comparator control word for reading
  function automatic logic [15:0] cc_word(input tcv_pkg::tcv_cmp_cfg_t c,
                                          input logic evt, input logic res);
    logic [15:0] w;
    w = 16'h0000;
    w[tcv_pkg::CC_ENABLE_BIT] = c.enable;
    w[tcv_pkg::CC_PINOUT_BIT] = c.pin_out;
    w[tcv_pkg::CC_INVERT_BIT] = c.output_invert;
    w[tcv_pkg::CC_EVENT_BIT] = evt;
    w[tcv_pkg::CC_RESULT_BIT] = res;
    w[tcv_pkg::CC_EDGE_LSB +: 2] = c.event_edge_select;
    w[tcv_pkg::CC_NONINV_BIT] = c.noninv_source_select;
    w[tcv_pkg::CC_CHAN_LSB +: 2] = c.inverting_channel_select;
    return w;
  endfunction

  // Address phase accepted on a selected, ready NONSEQ transfer; HSIZE is not decoded
  assign addr_ok = HSEL && HREADY && HTRANS == tcv_pkg::HTRANS_NONSEQ;

  // Comparator outputs are asynchronous, so two flops before any use
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      sync1_q <= '0;
      sync2_q <= '0;
      idle_s1_q <= 1'b0;
      idle_s2_q <= 1'b0;
    end else begin
      sync1_q <= RAW_CMP_OUT;
      sync2_q <= sync1_q;
      idle_s1_q <= IDLE_MODE;
      idle_s2_q <= idle_s1_q;
    end
  end

  // Polarity and edge detection on the synchronised result
  always_comb begin
    for (int i = 0; i < NUM_CMP; i++) begin
      res_d[i] = sync2_q[i] ^ cfg_q[i].output_invert;
      // Direction flips with the invert bit: codes name raw-side edges
      case (cfg_q[i].event_edge_select)
        tcv_pkg::EV_OFF: fire_d[i] = 1'b0;
        tcv_pkg::EV_RISE: fire_d[i] = cfg_q[i].output_invert ? (res_q[i] && !res_d[i])
                                                             : (!res_q[i] && res_d[i]);
        tcv_pkg::EV_FALL: fire_d[i] = cfg_q[i].output_invert ? (!res_q[i] && res_d[i])
                                                             : (res_q[i] && !res_d[i]);
        tcv_pkg::EV_ANY: fire_d[i] = res_q[i] != res_d[i];
        default: fire_d[i] = 1'b0;
      endcase
      // Disabled comparator never raises an event
      if (!cfg_q[i].enable) begin
        fire_d[i] = 1'b0;
      end
    end
  end

  // Previous result register for edge comparison
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      res_q <= '0;
    end else begin
      res_q <= res_d;
    end
  end

  // Sticky event flags; set wins over a same-cycle software clear
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      evt_q <= '0;
    end else begin
      for (int i = 0; i < NUM_CMP; i++) begin
        if (fire_d[i]) begin
          evt_q[i] <= 1'b1;
        end else if (wr_pend_q && cmp_index(addr_q) == i) begin
          evt_q[i] <= HWDATA[tcv_pkg::CC_EVENT_BIT];
        end
      end
    end
  end

  // Trigger and interrupt pulses, blocked while the flag stands
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      trig_q <= '0;
      irq_q <= '0;
    end else begin
      trig_q <= fire_d & ~evt_q;
      irq_q <= fire_d & ~evt_q & {NUM_CMP{!(idle_sup_q && idle_s2_q)}};
    end
  end

  // Bus address phase capture; always zero wait states
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      wr_pend_q <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_ok && HWRITE;
      if (addr_ok) begin
        addr_q <= HADDR[7:0];
      end
    end
  end

  // Comparator settings written in the data phase
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      for (int i = 0; i < NUM_CMP; i++) begin
        cfg_q[i] <= '0;
      end
    end else if (wr_pend_q && cmp_index(addr_q) < NUM_CMP) begin
      cfg_q[cmp_index(addr_q)] <= '{
        enable: HWDATA[tcv_pkg::CC_ENABLE_BIT],
        pin_out: HWDATA[tcv_pkg::CC_PINOUT_BIT],
        output_invert: HWDATA[tcv_pkg::CC_INVERT_BIT],
        event_edge_select: HWDATA[tcv_pkg::CC_EDGE_LSB +: 2],
        noninv_source_select: HWDATA[tcv_pkg::CC_NONINV_BIT],
        inverting_channel_select: HWDATA[tcv_pkg::CC_CHAN_LSB +: 2]
      };
    end
  end

  // Status idle bit and reference register
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      idle_sup_q <= 1'b0;
      vref_q <= tcv_pkg::VR_RESET;
    end else if (wr_pend_q) begin
      if (addr_q == tcv_pkg::STATUS_OFF) begin
        idle_sup_q <= HWDATA[tcv_pkg::ST_IDLE_BIT];
      end
      if (addr_q == tcv_pkg::VREF_CTRL_OFF) begin
        vref_q <= HWDATA[7:0];
      end
    end
  end

  // Read mux; unmapped offsets and unused bits read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (cmp_index(HADDR[7:0]) < NUM_CMP) begin
      for (int i = 0; i < NUM_CMP; i++) begin
        if (cmp_index(HADDR[7:0]) == i) begin
          rd_word[15:0] = cc_word(cfg_q[i], evt_q[i], res_d[i]);
        end
      end
    end else if (HADDR[7:0] == tcv_pkg::STATUS_OFF) begin
      rd_word[tcv_pkg::ST_IDLE_BIT] = idle_sup_q;
      rd_word[tcv_pkg::ST_EVT_LSB +: NUM_CMP] = evt_q;
      rd_word[tcv_pkg::ST_OUT_LSB +: NUM_CMP] = res_d;
    end else if (HADDR[7:0] == tcv_pkg::VREF_CTRL_OFF) begin
      rd_word[7:0] = vref_q;
    end
  end

  // Read data register loads at the address phase
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      rdata_q <= 32'h0000_0000;
    end else if (addr_ok && !HWRITE) begin
      rdata_q <= rd_word;
    end
  end

  assign HRDATA = rdata_q;
  assign HREADYOUT = 1'b1;
  assign HRESP = tcv_pkg::HRESP_OKAY;

  // Analog side controls
  always_comb begin
    for (int i = 0; i < NUM_CMP; i++) begin
      CMP_ENABLE[i] = cfg_q[i].enable;
      CMP_PIN_OUT_EN[i] = cfg_q[i].pin_out;
      NONINV_USE_REF[i] = cfg_q[i].noninv_source_select;
      INV_CHANNEL[2*i +: 2] = cfg_q[i].inverting_channel_select;
    end
  end

  assign CMP_RESULT = res_q;
  assign CMP_IRQ = irq_q;
  assign CMP_TRIGGER = trig_q;
  assign VREF_POWER = vref_q.reference_power_enable;
  assign VREF_PIN_EN = vref_q.reference_pin_enable;
  assign VREF_FINE_RANGE = vref_q.reference_range_select;
  assign VREF_EXT_SOURCE = vref_q.reference_source_select;
  assign VREF_LEVEL = vref_q.reference_level_code;
  // Fraction in 1/96ths: code*4 in fine, 24 + code*3 in coarse
  assign VREF_FRACTION = vref_q.reference_range_select
      ? {2'b00, vref_q.reference_level_code, 2'b00}
      : 8'(8'd24 + 8'(vref_q.reference_level_code) * 8'd3);

  // Flag rises the cycle after a qualifying event
  property p_evt_sets;
    @(posedge SYS_CLK) disable iff (SRST)
      fire_d[0] |=> evt_q[0];
  endproperty
  a_evt_sets: assert property (p_evt_sets) else $error("event flag not set");

  property p_no_retrigger;
    @(posedge SYS_CLK) disable iff (SRST)
      $past(evt_q[0]) && evt_q[0] |-> !trig_q[0];
  endproperty
  a_no_retrigger: assert property (p_no_retrigger) else $error("retrigger while flagged");

  property p_idle_mask;
    @(posedge SYS_CLK) disable iff (SRST)
      idle_sup_q && idle_s2_q |=> !CMP_IRQ[0] || !$past(idle_s2_q);
  endproperty
  a_idle_mask: assert property (p_idle_mask) else $error("irq in idle");

  property p_invert;
    @(posedge SYS_CLK) disable iff (SRST)
      res_d[0] == (sync2_q[0] ^ cfg_q[0].output_invert);
  endproperty
  a_invert: assert property (p_invert) else $error("polarity wrong");

  property p_sync;
    @(posedge SYS_CLK) disable iff (SRST)
      ##2 sync2_q == $past(RAW_CMP_OUT, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("sync depth wrong");

  property p_any_edge;
    @(posedge SYS_CLK) disable iff (SRST)
      cfg_q[0].enable && cfg_q[0].event_edge_select == tcv_pkg::EV_ANY
        && res_q[0] != res_d[0] |-> fire_d[0];
  endproperty
  a_any_edge: assert property (p_any_edge) else $error("any edge missed");

  property p_off;
    @(posedge SYS_CLK) disable iff (SRST)
      cfg_q[0].event_edge_select == tcv_pkg::EV_OFF |-> !fire_d[0];
  endproperty
  a_off: assert property (p_off) else $error("event while disabled");

  property p_vref_zero;
    @(posedge SYS_CLK) disable iff (SRST)
      addr_ok && !HWRITE && HADDR[7:0] == tcv_pkg::VREF_CTRL_OFF |=> HRDATA[31:8] == 24'h0;
  endproperty
  a_vref_zero: assert property (p_vref_zero) else $error("reserved bits set");

  property p_fraction;
    @(posedge SYS_CLK) disable iff (SRST)
      !VREF_FINE_RANGE |-> VREF_FRACTION >= 8'd24 && VREF_FRACTION <= 8'd69;
  endproperty
  a_fraction: assert property (p_fraction) else $error("coarse level off");

  // A software clear with no new event drops the flag
  property p_evt_clear;
    @(posedge SYS_CLK) disable iff (SRST)
      wr_pend_q && addr_q == tcv_pkg::CMP1_CTRL_OFF && !HWDATA[tcv_pkg::CC_EVENT_BIT]
        && !fire_d[0] |=> !evt_q[0];
  endproperty
  a_evt_clear: assert property (p_evt_clear) else $error("event flag not cleared");

  // Trigger lasts one cycle, the flag blocks the next
  property p_trig_once;
    @(posedge SYS_CLK) disable iff (SRST)
      CMP_TRIGGER[0] |=> !CMP_TRIGGER[0];
  endproperty
  a_trig_once: assert property (p_trig_once) else $error("trigger repeated");

  // An interrupt only ever rides along with a trigger
  property p_irq_with_trig;
    @(posedge SYS_CLK) disable iff (SRST)
      CMP_IRQ[0] |-> CMP_TRIGGER[0];
  endproperty
  a_irq_with_trig: assert property (p_irq_with_trig) else $error("irq without trigger");

endmodule // tcv_top
